// ==== verilog/dcld_top.sv ====
// Data-cache modified tracking, duplicate tags and load-locked/store-conditional handling
//
// The APB slave port and the address map were decided locally.

// What this block does
// R1 - Memory fill sets the line's modified bit
// R2 - Write to dirty line sets modified; evict writes back
// R3 - Keep physically indexed duplicate of virtual tags
// R4 - Fill: alias found, write back if modified, invalidate
// R5 - Fill: evict board-index conflicting line, keep subset
// R6 - Ifetch: write back modified data-cache copy first
// R7 - Ifetch index conflict: noncached fetch, no allocate
// R8 - Probes look up duplicate tags, core unstalled
// R9 - Load-locked miss: read-block command, fill clean
// R10 - Conditional store succeeds only if resident, writable
// R11 - Outside writers must send invalidating probe first
// R12 - Commands only for nonspeculative; success always writes
// R13 - Load-locked is store-like; conditional store waits
// R14 - Ifetch matching data-cache index becomes noncached
// R15 - Conditional store interrupting pair fails in order
// R16 - Older evicting load/store: replay trap, abort lock
// R17 - Stall map after conditional store until queue empty
// R18 - Fetch bit: load-locked sets, branches predicted not-taken
// R19 - Conditional store miss fails without system transaction
// R20 - Make-writable after retire and older stores writable
// R21 - Pin line against probes until store data written
// R22 - Firmware virtual load/store clears lock flag
module dcld_top
	import dcld_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// APB register port
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	// Cache traffic
	input  wire dcld_fill_s  fill,
	input  wire dcld_mop_s   mop,
	input  wire dcld_addr_s  probe,
	input  wire dcld_addr_s  ifetch,
	input  wire logic        sc_retired,
	input  wire logic        older_st_writable,
	input  wire logic        sys_resp_valid,
	input  wire logic        sys_resp_success,
	// Issue queue and fetch
	input  wire logic        map_valid,
	input  wire dcld_mop_e   map_kind,
	input  wire logic        iq_empty,
	input  wire logic        fetch_mem_valid,
	input  wire logic        fetch_is_ll,
	// Results
	output dcld_cmd_s        cmd,
	output dcld_addr_s       wb_alias,
	output dcld_addr_s       wb_victim,
	output dcld_ifr_s        ifr,
	output logic             probe_hit,
	output logic             probe_retry,
	output logic             sc_done,
	output logic             sc_ok,
	output logic             replay_trap,
	output logic             iq_store_like,
	output logic             iq_store_wait,
	output logic             map_stall,
	output logic             predict_not_taken
);
	// Primary tags and duplicate copy
	dcld_line_s       lines_q [NLINES];
	dcld_dup_s        dup_q   [NLINES];

	// Sequencer and lock flag
	dcld_sc_e         sc_q;
	logic             lock_q;
	logic [PA_W-1:0]  lock_pa_q;
	logic [IDX_W-1:0] lock_vidx_q;

	// Line awaiting its answer
	logic [PA_W-1:0]  mw_pa_q;
	logic [IDX_W-1:0] mw_vidx_q;

	// Control and outcome counters
	logic [1:0]       ctrl_q;
	logic [15:0]      sc_ok_cnt_q;
	logic [15:0]      sc_bad_cnt_q;

	// Physical index into the duplicate tags
	function automatic logic [IDX_W-1:0] pidx(input logic [PA_W-1:0] pa);
		return pa[IDX_W-1:0];
	endfunction : pidx

	// Primary lookup: line valid and holding this physical address
	function automatic logic line_hit(input dcld_line_s l, input logic [PA_W-1:0] pa);
		return l.valid && (l.pa == pa);
	endfunction : line_hit

	// Entries read from both tag copies
	dcld_dup_s  fill_occ, probe_ent, if_ent;
	dcld_line_s fill_occ_line, fill_tgt, mop_line, if_line;

	// Fill, probe and memory-op decisions
	logic       fill_alias_ev, fill_tgt_ev, probe_found, probe_pinned;
	logic       mop_hit, lock_live, mop_evicts_lock, fw_clear, sc_start;
	logic       wb_alias_go, wb_victim_go;

	// Conditional store and fetch decisions
	logic       sc_fast_fail, sc_fast_ok, sc_slow, rb_need, mw_launch, sc_gone;
	logic       if_conflict, if_modified;

	// Fill only ever consults one duplicate slot: every line sharing the
	// board-level index also shares this slot, so alias and subset checks merge
	assign fill_occ      = dup_q[pidx(fill.pa)];
	assign fill_occ_line = lines_q[fill_occ.vidx];
	assign fill_tgt      = lines_q[fill.vidx];
	assign fill_alias_ev = fill.valid && fill_occ.valid; // R4 R5
	// Target slot holds another line: displaced
	assign fill_tgt_ev   = fill.valid && fill_tgt.valid &&
		!(fill_occ.valid && fill_occ.vidx == fill.vidx);
	// Only modified lines go back to the board cache
	assign wb_alias_go   = fill_alias_ev && fill_occ_line.modified; // R4
	assign wb_victim_go  = fill_tgt_ev && fill_tgt.modified; // R2

	// Probe search runs on the duplicate copy, beside the core pipeline
	assign probe_ent    = dup_q[pidx(probe.pa)];
	assign probe_found  = probe.valid && probe_ent.valid && probe_ent.pa == probe.pa; // R8
	// Pinned line answers retry; prober comes back
	assign probe_pinned = probe_found && sc_q == SC_PINNED && mw_pa_q == probe.pa; // R21

	// Memory-op lookup and lock breakers
	assign mop_line  = lines_q[mop.vidx];
	assign mop_hit   = line_hit(mop_line, mop.pa);
	// Lock counts only while its line is resident
	assign lock_live = lock_q && line_hit(lines_q[lock_vidx_q], lock_pa_q);
	// Older access to the locked slot would evict it
	assign mop_evicts_lock = mop.valid && (mop.kind == MOP_LD || mop.kind == MOP_ST) &&
		mop.older_than_ll && lock_q && mop.vidx == lock_vidx_q &&
		mop.pa != lock_pa_q; // R16
	// Firmware-flow virtual access drops the lock
	assign fw_clear = mop.valid && mop.firmware &&
		(mop.kind == MOP_LD || mop.kind == MOP_ST); // R22

	// Conditional store classification
	assign sc_start     = mop.valid && mop.kind == MOP_SC && sc_q == SC_IDLE;
	assign sc_fast_fail = sc_start && !(lock_live && mop_hit && mop.pa == lock_pa_q); // R10 R15 R19
	// Dirty line is writable already: no traffic
	assign sc_fast_ok   = sc_start && !sc_fast_fail && mop_line.dirty;
	assign sc_slow      = sc_start && !sc_fast_fail && !mop_line.dirty; // R20
	// Load-locked miss fetches the whole block
	assign rb_need      = mop.valid && mop.kind == MOP_LL && !mop_hit; // R9
	// The line may vanish before launch; then no command goes out at all
	assign sc_gone      = !line_hit(lines_q[mw_vidx_q], mw_pa_q);
	// Read-block wins the shared command port; the launch simply waits a cycle
	assign mw_launch    = sc_q == SC_LAUNCH && !sc_gone && sc_retired &&
		older_st_writable && !rb_need; // R12 R20

	// Instruction fetch checks against the data cache
	assign if_ent      = dup_q[pidx(ifetch.pa)];
	assign if_line     = lines_q[if_ent.vidx];
	// Same slot, other address: a fill would evict it
	assign if_conflict = if_ent.valid && if_ent.pa != ifetch.pa; // R7 R14
	assign if_modified = if_ent.valid && if_ent.pa == ifetch.pa && if_line.modified; // R6

	// Tag arrays; probe invalidation is applied last so it wins over a fill
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NLINES; i++) begin
				lines_q[i] <= '0;
				dup_q[i]   <= '0;
			end
		end else begin
			// Alias or conflict leaves the primary copy
			if (fill_alias_ev)
				lines_q[fill_occ.vidx].valid <= 1'b0; // R4 R5
			// Displaced line leaves the duplicate copy
			if (fill_tgt_ev)
				dup_q[pidx(fill_tgt.pa)].valid <= 1'b0;
			// New line is modified so it reaches the board cache
			if (fill.valid) begin
				lines_q[fill.vidx] <= '{valid: 1'b1, pa: fill.pa, dirty: fill.writable,
					modified: 1'b1}; // R1 R9
				dup_q[pidx(fill.pa)] <= '{valid: 1'b1, pa: fill.pa, vidx: fill.vidx}; // R3
			end
			// Stores to writable lines mark them modified
			if (mop.valid && mop.kind == MOP_ST && mop_hit && mop_line.dirty)
				lines_q[mop.vidx].modified <= 1'b1; // R2
			if (sc_fast_ok)
				lines_q[mop.vidx].modified <= 1'b1;
			// Grant makes the line writable, then data lands
			if (sc_q == SC_RESP && sys_resp_valid && sys_resp_success)
				lines_q[mw_vidx_q].dirty <= 1'b1;
			if (sc_q == SC_PINNED)
				lines_q[mw_vidx_q].modified <= 1'b1; // R12
			// Written back ahead of the instruction fill
			if (ifetch.valid && if_modified)
				lines_q[if_ent.vidx].modified <= 1'b0; // R6
			// Probe removes both copies unless pinned
			if (probe_found && !probe_pinned) begin
				lines_q[probe_ent.vidx].valid <= 1'b0; // R8
				dup_q[pidx(probe.pa)].valid   <= 1'b0;
			end
		end
	end

	// Lock flag; counts only while its line is resident, so an evicted line disarms it until refilled
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lock_q      <= 1'b0;
			lock_pa_q   <= '0;
			lock_vidx_q <= '0;
		end else if (mop.valid && mop.kind == MOP_LL && !mop.firmware) begin
			// Lock enable off: every pair fails
			lock_q      <= ctrl_q[CTRL_LOCK_EN];
			lock_pa_q   <= mop.pa;
			lock_vidx_q <= mop.vidx;
		end else if (mop_evicts_lock || fw_clear || sc_start || sc_q == SC_PINNED) begin
			lock_q <= 1'b0; // R15 R16 R22
		end else if (probe_found && !probe_pinned && probe.pa == lock_pa_q) begin
			// Another agent is about to write the line
			lock_q <= 1'b0; // R11
		end
	end

	// Conditional store sequencer
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sc_q      <= SC_IDLE;
			mw_pa_q   <= '0;
			mw_vidx_q <= '0;
		end else begin
			case (sc_q)
				SC_IDLE: begin
					// Only a clean hit waits here
					if (sc_slow) begin
						sc_q      <= SC_LAUNCH;
						mw_pa_q   <= mop.pa;
						mw_vidx_q <= mop.vidx;
					end
				end
				SC_LAUNCH: begin
					// Lost line fails without going out
					if (sc_gone)
						sc_q <= SC_IDLE; // R10
					else if (mw_launch)
						sc_q <= SC_RESP;
				end
				SC_RESP: begin
					// Refusal fails; success pins the line
					if (sys_resp_valid)
						sc_q <= sys_resp_success ? SC_PINNED : SC_IDLE; // R21
				end
				SC_PINNED: sc_q <= SC_IDLE;
				default:   sc_q <= SC_IDLE;
			endcase
		end
	end

	// Registered command, writeback and result outputs
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cmd         <= '0;
			wb_alias    <= '0;
			wb_victim   <= '0;
			ifr         <= '0;
			probe_hit   <= 1'b0;
			probe_retry <= 1'b0;
			sc_done     <= 1'b0;
			sc_ok       <= 1'b0;
			replay_trap <= 1'b0;
		end else begin
			// One command port, read-block first
			cmd.valid <= rb_need || mw_launch;
			cmd.kind  <= rb_need ? CMD_READ_BLOCK : (mw_launch ? CMD_MAKE_WRITABLE : CMD_NONE);
			cmd.pa    <= rb_need ? mop.pa : mw_pa_q; // R9 R20
			// Address reads zero between pulses, never a stale tag
			wb_alias.valid  <= wb_alias_go; // R4
			wb_alias.pa     <= wb_alias_go ? fill_occ.pa : '0;
			wb_victim.valid <= wb_victim_go; // R2
			wb_victim.pa    <= wb_victim_go ? fill_tgt.pa : '0;
			// Instruction fill verdict
			ifr.valid           <= ifetch.valid;
			ifr.noncached       <= if_conflict; // R7 R14
			ifr.writeback_first <= if_modified; // R6
			ifr.pa              <= ifetch.pa;
			probe_hit   <= probe_found && !probe_pinned;
			probe_retry <= probe_pinned; // R21
			// Every way a conditional store finishes
			sc_done <= sc_fast_fail || sc_fast_ok || sc_q == SC_PINNED ||
				(sc_q == SC_LAUNCH && sc_gone) ||
				(sc_q == SC_RESP && sys_resp_valid && !sys_resp_success);
			sc_ok       <= sc_fast_ok || sc_q == SC_PINNED; // R12
			replay_trap <= mop_evicts_lock; // R16
		end
	end

	// Issue queue wait tracking, map stall and fetch prediction bit
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			iq_store_like     <= 1'b0;
			iq_store_wait     <= 1'b0;
			map_stall         <= 1'b0;
			predict_not_taken <= 1'b0;
		end else begin
			// Load-locked waits like a store
			iq_store_like <= map_valid && (map_kind == MOP_ST || map_kind == MOP_LL); // R13
			iq_store_wait <= map_valid && map_kind == MOP_SC; // R13
			// Set wins over the queue draining in the same cycle
			if (map_valid && map_kind == MOP_SC)
				map_stall <= 1'b1; // R17
			else if (iq_empty)
				map_stall <= 1'b0;
			// Any other memory reference clears it
			if (fetch_mem_valid)
				predict_not_taken <= fetch_is_ll; // R18
		end
	end

	// APB slave: zero wait states, read data latched in the setup cycle
	logic apb_setup, apb_wr, addr_ok;
	assign apb_setup = psel && !penable;
	assign apb_wr    = psel && penable && pwrite;
	assign addr_ok   = paddr == REG_CTRL || paddr == REG_STATUS ||
		paddr == REG_SC_OK || paddr == REG_SC_BAD;
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && !addr_ok;

	// Status word placed by field position
	logic [31:0] status_w;
	always_comb begin
		status_w                   = 32'h0;
		status_w[ST_LOCK]          = lock_q;
		status_w[ST_FSM_LO +: 4]   = sc_q;
		status_w[ST_PA_LO +: PA_W] = lock_pa_q;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prdata <= '0;
		end else if (apb_setup) begin
			case (paddr)
				REG_CTRL:   prdata <= {30'h0, ctrl_q};
				REG_STATUS: prdata <= status_w;
				REG_SC_OK:  prdata <= {16'h0, sc_ok_cnt_q};
				REG_SC_BAD: prdata <= {16'h0, sc_bad_cnt_q};
				default:    prdata <= 32'h0;
			endcase
		end
	end

	// Control register; the clear bit is self-clearing
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			ctrl_q <= CTRL_RESET;
		else if (apb_wr && paddr == REG_CTRL)
			ctrl_q <= pwdata[1:0];
		else
			ctrl_q[CTRL_CNT_CLR] <= 1'b0;
	end

	// Outcome counters let software spot a livelocked lock sequence
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sc_ok_cnt_q  <= '0;
			sc_bad_cnt_q <= '0;
		end else if (ctrl_q[CTRL_CNT_CLR]) begin
			// Clear wins; a store ending now goes uncounted
			sc_ok_cnt_q  <= '0;
			sc_bad_cnt_q <= '0;
		end else if (sc_done) begin
			if (sc_ok)
				sc_ok_cnt_q <= sc_ok_cnt_q + 16'h1;
			else
				sc_bad_cnt_q <= sc_bad_cnt_q + 16'h1;
		end
	end
endmodule : dcld_top

// ==== verilog/dcld_pkg.sv ====
// Shared constants, types and register map of the data-cache lock and duplicate tag block
package dcld_pkg;
	localparam int NLINES = 8;  // Data-cache lines
	localparam int IDX_W  = 3;  // Index width of both tag copies
	localparam int PA_W   = 12; // Physical line address width
	localparam int BIDX_W = 6;  // Board-level cache index width, covers IDX_W low bits

	// Register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_SC_OK  = 8'h08;
	localparam logic [7:0] REG_SC_BAD = 8'h0c;
	// Field positions and reset values
	localparam int CTRL_LOCK_EN   = 0;
	localparam int CTRL_CNT_CLR   = 1;
	localparam int ST_LOCK        = 0;
	localparam int ST_FSM_LO      = 4;
	localparam int ST_PA_LO       = 16;
	localparam logic [1:0] CTRL_RESET = 2'h1;

	// Memory operation kinds
	typedef enum logic [1:0] {
		MOP_LD = 2'h0,
		MOP_ST = 2'h1,
		MOP_LL = 2'h2,
		MOP_SC = 2'h3
	} dcld_mop_e;

	// Outgoing system commands
	typedef enum logic [1:0] {
		CMD_NONE          = 2'h0,
		CMD_READ_BLOCK    = 2'h1,
		CMD_MAKE_WRITABLE = 2'h2
	} dcld_cmd_e;

	// Conditional-store sequencer states
	typedef enum logic [3:0] {
		SC_IDLE   = 4'b0001,
		SC_LAUNCH = 4'b0010,
		SC_RESP   = 4'b0100,
		SC_PINNED = 4'b1000
	} dcld_sc_e;

	// Primary (virtually indexed) line state
	typedef struct packed {
		logic            valid;
		logic [PA_W-1:0] pa;
		logic            dirty;    // Writable in the coherence protocol
		logic            modified; // Must go to the board-level cache on eviction
	} dcld_line_s;

	// Duplicate (physically indexed) tag entry
	typedef struct packed {
		logic             valid;
		logic [PA_W-1:0]  pa;
		logic [IDX_W-1:0] vidx;
	} dcld_dup_s;

	typedef struct packed {
		logic             valid;
		logic [IDX_W-1:0] vidx;
		logic [PA_W-1:0]  pa;
		logic             writable;
	} dcld_fill_s;

	typedef struct packed {
		logic             valid;
		dcld_mop_e        kind;
		logic [IDX_W-1:0] vidx;
		logic [PA_W-1:0]  pa;
		logic             older_than_ll;
		logic             firmware;
	} dcld_mop_s;

	typedef struct packed {
		logic            valid;
		logic [PA_W-1:0] pa;
	} dcld_addr_s;

	typedef struct packed {
		logic            valid;
		dcld_cmd_e       kind;
		logic [PA_W-1:0] pa;
	} dcld_cmd_s;

	typedef struct packed {
		logic            valid;
		logic            noncached;
		logic            writeback_first;
		logic [PA_W-1:0] pa;
	} dcld_ifr_s;
endpackage : dcld_pkg

// ==== bench/dcld_sys_model.sv ====
// Coherence controller stand-in that answers make-writable commands
module dcld_sys_model
	import dcld_pkg::*;
(
	input  wire logic      ref_clk,
	input  wire logic      rst,
	input  wire dcld_cmd_s cmd,
	input  wire logic      slow,
	input  wire logic      deny,
	output logic           resp_valid,
	output logic           resp_success
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] wait_q;
	logic       pend_q;

	// One answer per command, after one cycle or five when slow
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pend_q       <= 1'b0;
			wait_q       <= 3'h0;
			resp_valid   <= 1'b0;
			resp_success <= 1'b0;
		end else begin
			resp_valid   <= 1'b0;
			resp_success <= ~resp_success; // Meaningless outside the pulse
			if (cmd.valid && cmd.kind == CMD_MAKE_WRITABLE) begin
				pend_q <= 1'b1;
				wait_q <= slow ? 3'h4 : 3'h0;
			end else if (pend_q && wait_q != 3'h0) begin
				wait_q <= wait_q - 3'h1;
			end else if (pend_q) begin
				pend_q       <= 1'b0;
				resp_valid   <= 1'b1;
				resp_success <= ~deny;
			end
		end
	end
endmodule : dcld_sys_model

// ==== bench/dcld_top_asserts.sv ====
// Port checker for the lock and duplicate tag block
module dcld_top_asserts
	import dcld_pkg::*;
(
	input wire logic      ref_clk,
	input wire logic      rst,
	input wire dcld_mop_s mop,
	input wire dcld_cmd_s cmd,
	input wire logic      sc_retired,
	input wire logic      older_st_writable,
	input wire logic      sys_resp_valid,
	input wire logic      sys_resp_success,
	input wire logic      sc_done,
	input wire logic      sc_ok,
	input wire logic      map_valid,
	input wire dcld_mop_e map_kind,
	input wire logic      iq_empty,
	input wire logic      iq_store_like,
	input wire logic      iq_store_wait,
	input wire logic      map_stall,
	input wire logic      fetch_mem_valid,
	input wire logic      fetch_is_ll,
	input wire logic      predict_not_taken,
	input wire logic      replay_trap
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// Commands only ever follow their cause by one cycle
	a_read_block_command_from_ll: assert property (cmd.valid && cmd.kind == CMD_READ_BLOCK |->
		$past(mop.valid) && $past(mop.kind) == MOP_LL && $past(mop.pa) == cmd.pa)
		else $error("read-block without load-locked");
	a_mkwr_after_retire: assert property (cmd.valid && cmd.kind == CMD_MAKE_WRITABLE |->
		$past(sc_retired) && $past(older_st_writable)) else $error("early make-writable");
	// Far-side answers decide the outcome
	a_resp_ok_done: assert property (sys_resp_valid && sys_resp_success |->
		##[1:2] (sc_done && sc_ok)) else $error("granted store not completed");
	a_resp_bad_fail: assert property (sys_resp_valid && !sys_resp_success |=>
		sc_done && !sc_ok) else $error("refused store not failed");
	// Issue queue and fetch bookkeeping, replay cause and covers
	a_store_like: assert property (map_valid |=> iq_store_like ==
		($past(map_kind) == MOP_LL || $past(map_kind) == MOP_ST)) else $error("store-like");
	a_sc_wait_stall: assert property (map_valid && map_kind == MOP_SC |=>
		iq_store_wait && map_stall) else $error("conditional store not held");
	a_stall_hold: assert property (map_stall && !iq_empty |=> map_stall)
		else $error("stall dropped early");
	a_fetch_bit: assert property (fetch_mem_valid |=>
		predict_not_taken == $past(fetch_is_ll)) else $error("fetch bit wrong");
	a_replay_cause: assert property (replay_trap |->
		$past(mop.valid) && $past(mop.older_than_ll)) else $error("replay without cause");
	c_sc_success: cover property (sc_done && sc_ok);
	c_replay: cover property (replay_trap);
	c_stall_release: cover property (map_stall ##1 !map_stall);
endmodule : dcld_top_asserts

bind dcld_top dcld_top_asserts u_dcld_top_asserts (.ref_clk, .rst, .mop, .cmd, .sc_retired,
	.older_st_writable, .sys_resp_valid, .sys_resp_success, .sc_done, .sc_ok, .map_valid,
	.map_kind, .iq_empty, .iq_store_like, .iq_store_wait, .map_stall, .fetch_mem_valid,
	.fetch_is_ll, .predict_not_taken, .replay_trap);

// ==== bench/test_dcld_top.sv ====
// Self-checking bench for the lock and duplicate tag block
module test_dcld_top
	import dcld_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	dcld_fill_s  fill = '0;
	dcld_mop_s   mop = '0;
	dcld_addr_s  probe = '0;
	dcld_addr_s  ifetch = '0;
	logic        sc_retired = 1'b0;
	logic        older_st_writable = 1'b0;
	logic        map_valid = 1'b0;
	dcld_mop_e   map_kind = MOP_LD;
	logic        iq_empty = 1'b0;
	logic        fetch_mem_valid = 1'b0;
	logic        fetch_is_ll = 1'b0;
	logic        slow = 1'b0;
	logic        deny = 1'b0;
	dcld_cmd_s   cmd;
	dcld_addr_s  wb_alias, wb_victim;
	dcld_ifr_s   ifr;
	logic        pready, pslverr, sys_resp_valid, sys_resp_success, probe_hit, probe_retry;
	logic        sc_done, sc_ok, replay_trap, iq_store_like, iq_store_wait;
	logic        map_stall, predict_not_taken, err, done, okv, es, ep;
	logic [11:0] a;
	logic [31:0] rd, r;
	int          mismatches = 0;
	int          compares = 0;

	dcld_top u_dcld_top (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.pslverr, .prdata, .fill, .mop, .probe, .ifetch, .sc_retired, .older_st_writable,
		.sys_resp_valid, .sys_resp_success, .map_valid, .map_kind, .iq_empty, .fetch_mem_valid,
		.fetch_is_ll, .cmd, .wb_alias, .wb_victim, .ifr, .probe_hit, .probe_retry, .sc_done,
		.sc_ok, .replay_trap, .iq_store_like, .iq_store_wait, .map_stall, .predict_not_taken);
	dcld_sys_model u_dcld_sys_model (.ref_clk, .rst, .cmd, .slow, .deny,
		.resp_valid(sys_resp_valid), .resp_success(sys_resp_success));

	// 125 MHz core clock
	always #4 ref_clk = ~ref_clk;

	task automatic final_report();
		$display("Compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : final_report

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// Bounded wait; a hang ends the run through the report
	task automatic give_up(input logic ok);
		if (ok !== 1'b1) begin
			mismatches++;
			final_report();
		end
	endtask : give_up

	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= ad;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		give_up(pready);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// One cycle of traffic, then settle past the sampling edge
	task automatic step();
		@(posedge ref_clk);
		fill              <= '0;
		mop               <= '0;
		probe             <= '0;
		ifetch            <= '0;
		sc_retired        <= 1'b0;
		older_st_writable <= 1'b0;
		#1;
	endtask : step

	task automatic do_mop(input dcld_mop_e k, input logic [2:0] v, input logic [11:0] pa,
		input logic [1:0] f);
		@(posedge ref_clk);
		mop <= '{1'b1, k, v, pa, f[1], f[0]};
		step();
	endtask : do_mop

	task automatic do_fill(input logic [2:0] v, input logic [11:0] pa, input logic w);
		@(posedge ref_clk);
		fill <= '{1'b1, v, pa, w};
		step();
	endtask : do_fill

	task automatic await(input logic resp);
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while ((resp ? sys_resp_valid : cmd.valid) !== 1'b1 && n < 40);
		give_up(resp ? sys_resp_valid : cmd.valid);
	endtask : await

	function automatic logic nxt_stall(input logic [31:0] v, input logic s);
		return (v[0] && v[2:1] == 2'h3) ? 1'b1 : (v[3] ? 1'b0 : s);
	endfunction : nxt_stall

	// Main sequence
	initial begin
		r = $urandom(32'hfcdd);
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		apb(1'b0, REG_CTRL, 32'h0, rd, err);
		chk("ctrl", 32'h1, rd);
		apb(1'b0, REG_STATUS, 32'h0, rd, err);
		chk("status", 32'h10, rd);
		apb(1'b0, 8'h14, 32'h0, rd, err);
		chk("hole", 32'h0, rd);
		chk("hole_err", 32'h1, err);
		$display("Test registers done");
		// Locked pair granted fast, then refused slowly
		for (int i = 0; i < 2; i++) begin
			a = i ? 12'h0b6 : 12'h0a5;
			do_mop(MOP_LL, 3'(i + 1), a, 2'h0);
			chk("read_block_command", {1'b1, CMD_READ_BLOCK, a}, cmd);
			do_fill(3'(i + 1), a, 1'b0);
			apb(1'b0, REG_STATUS, 32'h0, rd, err);
			chk("lock", {4'h0, a, 16'h0011}, rd);
			do_mop(MOP_SC, 3'(i + 1), a, 2'h0);
			repeat (3) step();
			chk("early", 32'h0, {cmd.valid, sc_done});
			@(posedge ref_clk);
			sc_retired        <= 1'b1;
			older_st_writable <= 1'b1;
			slow              <= i[0];
			deny              <= i[0];
			await(1'b0);
			chk("mkwr", {1'b1, CMD_MAKE_WRITABLE, a}, cmd);
			await(1'b1);
			probe <= '{1'b1, a};
			#1;
			done = sc_done;
			okv  = sc_done & sc_ok;
			step();
			chk("done", 32'h1, done | sc_done);
			chk("ok", !i, okv | (sc_done & sc_ok));
			chk("retry", !i, probe_retry);
		end
		$display("Test locked pair done");
		// No open pair, then a miss: fast failure without a command
		for (int i = 0; i < 2; i++) begin
			do_mop(MOP_SC, i ? 3'h3 : 3'h1, i ? 12'h0c7 : 12'h0a5, 2'h0);
			chk("fail", 32'h4, {sc_done, sc_ok, cmd.valid});
		end
		// Dirty line with the lock held succeeds at once, no command
		do_mop(MOP_LL, 3'h1, 12'h0a5, 2'h0);
		do_mop(MOP_SC, 3'h1, 12'h0a5, 2'h0);
		chk("fastok", 32'h6, {sc_done, sc_ok, cmd.valid});
		// Older evicting load, then firmware load, each breaking the pair
		for (int i = 0; i < 2; i++) begin
			do_mop(MOP_LL, 3'h1, 12'h0a5, 2'h0);
			chk("llhit", 32'h0, cmd.valid);
			do_mop(MOP_LD, 3'h1, 12'h0d1, i ? 2'h1 : 2'h2);
			chk("trap", !i, replay_trap);
			do_mop(MOP_SC, 3'h1, 12'h0a5, 2'h0);
			chk("abort", 32'h4, {sc_done, sc_ok, cmd.valid});
		end
		$display("Test pair breaking done");
		// Alias, duplicate-slot conflict, displaced modified line
		for (int i = 0; i < 3; i++) begin
			do_fill(i ? 3'h5 : 3'h4, i == 0 ? 12'h0a5 : i == 1 ? 12'h0d5 : 12'h0e6, i < 2);
			chk("alias", i < 2 ? 32'h10a5 : 32'h0, wb_alias);
			chk("victim", i == 2 ? 32'h10d5 : 32'h0, wb_victim);
		end
		// Instruction fills: write back first, noncached, plain
		for (int i = 0; i < 3; i++) begin
			@(posedge ref_clk);
			ifetch <= '{1'b1, i == 0 ? 12'h0e6 : i == 1 ? 12'h0f6 : 12'h017};
			step();
			chk("ifr", i == 0 ? 32'h50e6 : i == 1 ? 32'h60f6 : 32'h4017, ifr);
		end
		for (int i = 0; i < 2; i++) begin
			@(posedge ref_clk);
			probe <= '{1'b1, i ? 12'h0e6 : 12'h0f6};
			step();
			chk("probe", i, probe_hit);
		end
		$display("Test tags done");
		// Random issue and fetch traffic
		es = 1'b0;
		ep = 1'b0;
		for (int n = 0; n < 300; n++) begin
			r = $urandom;
			@(posedge ref_clk);
			map_valid       <= r[0];
			map_kind        <= dcld_mop_e'(r[2:1]);
			iq_empty        <= r[3];
			fetch_mem_valid <= r[5];
			fetch_is_ll     <= r[6];
			@(posedge ref_clk);
			#1;
			es = nxt_stall(r, es);
			ep = r[5] ? r[6] : ep;
			chk("like", r[0] & (r[2:1] == 2'h2 | r[2:1] == 2'h1), iq_store_like);
			chk("wait", r[0] & r[2] & r[1], iq_store_wait);
			chk("stall", es, map_stall);
			chk("ntk", ep, predict_not_taken);
		end
		$display("Test random issue done");
		apb(1'b0, REG_SC_OK, 32'h0, rd, err);
		chk("okcnt", 32'h2, rd);
		apb(1'b0, REG_SC_BAD, 32'h0, rd, err);
		chk("badcnt", 32'h5, rd);
		apb(1'b1, REG_CTRL, 32'h3, rd, err);
		apb(1'b0, REG_SC_BAD, 32'h0, rd, err);
		chk("cleared", 32'h0, rd);
		$display("Test counters done");
		final_report();
	end
endmodule : test_dcld_top
